// ==== common/rsw_pkg.sv ====
`default_nettype none
package rsw_pkg;

   // ------------------------------------------------------------------
   // Register addresses on the special function register port
   // ------------------------------------------------------------------
   localparam logic [7:0] REG_WD_RELOAD = 8'ha6;
   localparam logic [7:0] REG_WD_KEY = 8'hae;
   localparam logic [7:0] REG_PWR_CTRL = 8'h87;
   localparam logic [7:0] REG_USB_ISTA = 8'he8;
   localparam logic [7:0] REG_USB_IEN = 8'he9;

   // ------------------------------------------------------------------
   // Field positions and values
   // ------------------------------------------------------------------
   localparam int PWR_LOWV_DIS_BIT = 5;
   localparam int USB_IEN_RST_EN_BIT = 6;
   localparam int USB_ISTA_RST_FLAG_BIT = 4;
   localparam logic [7:0] WD_RELOAD_MAX = 8'h7e;
   localparam logic [7:0] WD_KEY_OFF = 8'h55;
   localparam logic [7:0] REG_RESET_VAL = 8'h00;
   localparam int WD_CNT_W = 22;
   localparam int WD_RELOAD_W = 7;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int OSC_PER_MCYCLE = 12;
   localparam logic [3:0] MC_DIV_LAST = 4'(OSC_PER_MCYCLE - 1);
   localparam int LOWV_HOLD_MS = 10;
   localparam int LOWV_HOLD_CYC_DEF =
      (LOWV_HOLD_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOWV_FILT_US = 1;
   localparam int LOWV_FILT_CYC_DEF =
      (LOWV_FILT_US * 1_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WD_PULSE_EXP = 15;
   localparam int WD_PULSE_MC_DEF = 2 ** WD_PULSE_EXP;
   localparam int USB_SE0_MIN = 4;
   localparam logic [3:0] USB_SE0_LAST = 4'(USB_SE0_MIN - 1);

   typedef enum logic {WD_RUN, WD_PULSE} rsw_wd_state_t;

endpackage
`default_nettype wire

// ==== common/rsw_flt_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface rsw_flt_if;
   logic raw;
   logic clean;
   modport src (output raw, input clean);
   modport flt (input raw, output clean);
endinterface
`default_nettype wire

// ==== rtl/rsw_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
module rsw_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   // First stage feeds the second stage only
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_ff <= RST_VAL;
         q_ff <= RST_VAL;
      end
      else
      begin
         meta_ff <= d;
         q_ff <= meta_ff;
      end
   end

   assign q = q_ff;
endmodule // rsw_sync
`default_nettype wire

// ==== rtl/rsw_filter.sv ====
`timescale 1ns/1ns
`default_nettype none
module rsw_filter import rsw_pkg::*; #(
   parameter int N = LOWV_FILT_CYC_DEF
) (
   input wire logic clk,
   input wire logic rst_b,
   rsw_flt_if.flt port
);
   localparam int CW = $clog2(N + 1);
   logic [CW-1:0] cnt_ff;
   logic clean_ff;

   // Output follows the input only after N steady cycles, either way
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_ff <= '0;
         clean_ff <= 1'b0;
      end
      else if (port.raw == clean_ff)
      begin
         cnt_ff <= '0;
      end
      else if (cnt_ff == CW'(N - 1))
      begin
         cnt_ff <= '0;
         clean_ff <= port.raw;
      end
      else
      begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   assign port.clean = clean_ff;

   filt_rise_a: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(clean_ff) |-> $past(port.raw, N) && $past(port.raw, 1))
      else $error("Filtered level rose without a steady input");
endmodule // rsw_filter
`default_nettype wire

// ==== rtl/rsw_top.sv ====
// Function
// - Any of pin, low voltage, USB bus reset or watchdog asserts internal reset.
// - Internal reset goes to the programmable logic as an active-low reset.
// - After low voltage clears, reset stays asserted a further 10 ms.
// - Low-voltage reset enabled after power-up; software may disable it.
// - Power control bit 5 set disables low-voltage reset; clear keeps it enabled.
// - Low-voltage reset keeps working in idle and power-down modes.
// - Low-voltage pulses shorter than about 1 us are filtered out.
// - Single-ended zero seen on 4 consecutive machine-cycle ticks sets the USB bus reset flag.
// - With USB reset enable bit 6 set, USB bus reset asserts internal reset.
// - Watchdog 22-bit counter advances once per machine cycle while enabled.
// - Watchdog counter overflowing past all ones generates internal reset.
// - Software reloads with 00 to 7E; value goes to seven counter MSBs.
// - Writing zero to the reload register clears the whole counter.
// - Only key 55 hex disables the watchdog; other keys keep it enabled.
// - Watchdog comes out of power-up and every reset enabled.
// - In idle mode watchdog and reset logic keep running.
// - Watchdog reset pulse lasts 2^15 machine cycles.
`timescale 1ns/1ns
`default_nettype none
module rsw_top import rsw_pkg::*; #(
   parameter int LOWV_HOLD_CYC = LOWV_HOLD_CYC_DEF,
   parameter int WD_PULSE_MC = WD_PULSE_MC_DEF,
   parameter int LOWV_FILT_CYC = LOWV_FILT_CYC_DEF,
   parameter int WD_W = WD_CNT_W
) (
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic RESET_PIN_B,
   input wire logic LOWV_DET,
   input wire logic USB_SE0,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   output logic CPU_RST,
   output logic PLD_RST_B,
   output logic USB_RST_FLAG,
   output logic [7:0] REG_RDATA
);
   localparam int HW = $clog2(LOWV_HOLD_CYC + 1);
   localparam int PW = $clog2(WD_PULSE_MC);

   // ------------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------------
   logic [2:0] pin_s;
   logic ext_req;
   logic lowv_s;
   logic se0_s;

   // Reset value reads as pin asserted so nothing escapes at power-up
   rsw_sync #(.W(3), .RST_VAL(3'h0)) u_sync (
      .clk(MCLK),
      .rst_b(RST_B),
      .d({RESET_PIN_B, LOWV_DET, USB_SE0}),
      .q(pin_s)
   );

   assign ext_req = ~pin_s[2];
   assign lowv_s = pin_s[1];
   assign se0_s = pin_s[0];

   // ------------------------------------------------------------------
   // Machine cycle tick
   // ------------------------------------------------------------------
   logic [3:0] div_ff;
   logic mtick_ff;

   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         div_ff <= 4'h0;
         mtick_ff <= 1'b0;
      end
      else if (div_ff == MC_DIV_LAST)
      begin
         div_ff <= 4'h0;
         mtick_ff <= 1'b1;
      end
      else
      begin
         div_ff <= div_ff + 4'h1;
         mtick_ff <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------------
   logic cpu_rst_ff;
   logic reg_we;
   logic lowv_dis_ff;
   logic usb_rst_en_ff;
   logic [7:0] key_ff;

   // CPU is held in reset, so its writes are not taken then
   assign reg_we = REG_WR & ~cpu_rst_ff;

   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         lowv_dis_ff <= 1'b0;
      end
      else if (cpu_rst_ff)
      begin
         lowv_dis_ff <= 1'b0;
      end
      else if (reg_we && REG_ADDR == REG_PWR_CTRL)
      begin
         lowv_dis_ff <= REG_WDATA[PWR_LOWV_DIS_BIT];
      end
   end

   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         key_ff <= REG_RESET_VAL;
      end
      else if (cpu_rst_ff)
      begin
         key_ff <= REG_RESET_VAL;
      end
      else if (reg_we && REG_ADDR == REG_WD_KEY)
      begin
         key_ff <= REG_WDATA;
      end
   end

   // USB enable survives internal resets so a USB reset cannot cancel itself
   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         usb_rst_en_ff <= 1'b0;
      end
      else if (reg_we && REG_ADDR == REG_USB_IEN)
      begin
         usb_rst_en_ff <= REG_WDATA[USB_IEN_RST_EN_BIT];
      end
   end

   // ------------------------------------------------------------------
   // Low-voltage reset
   // ------------------------------------------------------------------
   rsw_flt_if lowv_if ();
   logic lowv_filt;
   logic [HW-1:0] hold_ff;
   logic lowv_req;

   assign lowv_if.raw = lowv_s;

   rsw_filter #(.N(LOWV_FILT_CYC)) u_filter (
      .clk(MCLK),
      .rst_b(RST_B),
      .port(lowv_if.flt)
   );

   assign lowv_filt = lowv_if.clean;

   // No idle or power-down input exists here, so nothing can stop it
   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         hold_ff <= '0;
      end
      else if (lowv_filt && !lowv_dis_ff)
      begin
         hold_ff <= HW'(LOWV_HOLD_CYC);
      end
      else if (hold_ff != '0)
      begin
         hold_ff <= hold_ff - 1'b1;
      end
   end

   assign lowv_req = (lowv_filt & ~lowv_dis_ff) | (hold_ff != '0);

   // ------------------------------------------------------------------
   // USB bus reset detection
   // ------------------------------------------------------------------
   logic [3:0] se0_run_ff;
   logic usb_det;
   logic usb_flag_ff;
   logic usb_req_ff;

   assign usb_det = mtick_ff & se0_s & (se0_run_ff == USB_SE0_LAST);

   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         se0_run_ff <= 4'h0;
      end
      else if (mtick_ff)
      begin
         if (!se0_s)
         begin
            se0_run_ff <= 4'h0;
         end
         else if (se0_run_ff <= USB_SE0_LAST)
         begin
            se0_run_ff <= se0_run_ff + 4'h1;
         end
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         usb_flag_ff <= 1'b0;
      end
      else if (usb_det)
      begin
         usb_flag_ff <= 1'b1;
      end
      else if (reg_we && REG_ADDR == REG_USB_ISTA && REG_WDATA[USB_ISTA_RST_FLAG_BIT])
      begin
         usb_flag_ff <= 1'b0;
      end
   end

   // Held until the zero state on the bus ends
   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         usb_req_ff <= 1'b0;
      end
      else if (usb_det && usb_rst_en_ff)
      begin
         usb_req_ff <= 1'b1;
      end
      else if (!se0_s)
      begin
         usb_req_ff <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Watchdog
   // ------------------------------------------------------------------
   logic wd_en;
   logic wd_reload;
   logic wd_ovf;
   logic [WD_W-1:0] wd_cnt_ff;
   logic [PW-1:0] wd_pcnt_ff;
   rsw_wd_state_t wd_state_ff;

   assign wd_en = key_ff != WD_KEY_OFF;
   assign wd_reload = reg_we & (REG_ADDR == REG_WD_RELOAD) & (REG_WDATA <= WD_RELOAD_MAX);
   assign wd_ovf = mtick_ff & wd_en & ~cpu_rst_ff & ~wd_reload & (&wd_cnt_ff);

   // Out-of-range reloads are ignored rather than trusted
   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         wd_cnt_ff <= '0;
      end
      else if (cpu_rst_ff)
      begin
         wd_cnt_ff <= '0;
      end
      else if (wd_reload)
      begin
         wd_cnt_ff <= {REG_WDATA[WD_RELOAD_W-1:0],
                       {(WD_W - WD_RELOAD_W){1'b0}}};
      end
      else if (mtick_ff && wd_en)
      begin
         wd_cnt_ff <= wd_cnt_ff + 1'b1;
      end
   end

   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         wd_state_ff <= WD_RUN;
         wd_pcnt_ff <= '0;
      end
      else
      begin
         unique case (wd_state_ff)
            WD_RUN:
            begin
               wd_pcnt_ff <= '0;
               if (wd_ovf)
               begin
                  wd_state_ff <= WD_PULSE;
               end
            end
            WD_PULSE:
            begin
               if (mtick_ff && wd_pcnt_ff == PW'(WD_PULSE_MC - 1))
               begin
                  wd_state_ff <= WD_RUN;
               end
               else if (mtick_ff)
               begin
                  wd_pcnt_ff <= wd_pcnt_ff + 1'b1;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Combined reset and read-back
   // ------------------------------------------------------------------
   logic any_req;
   logic pld_rst_b_ff;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;

   assign any_req = ext_req | lowv_req | usb_req_ff | (wd_state_ff == WD_PULSE);

   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         cpu_rst_ff <= 1'b1;
         pld_rst_b_ff <= 1'b0;
      end
      else
      begin
         cpu_rst_ff <= any_req;
         pld_rst_b_ff <= ~any_req;
      end
   end

   always_comb
   begin
      nxt_rdata = REG_RESET_VAL;
      unique case (REG_ADDR)
         REG_WD_RELOAD: nxt_rdata = {1'b0, wd_cnt_ff[WD_W-1 -: WD_RELOAD_W]};
         REG_WD_KEY: nxt_rdata = key_ff;
         REG_PWR_CTRL: nxt_rdata[PWR_LOWV_DIS_BIT] = lowv_dis_ff;
         REG_USB_IEN: nxt_rdata[USB_IEN_RST_EN_BIT] = usb_rst_en_ff;
         REG_USB_ISTA: nxt_rdata[USB_ISTA_RST_FLAG_BIT] = usb_flag_ff;
         default: nxt_rdata = REG_RESET_VAL;
      endcase
   end

   always_ff @(posedge MCLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         rdata_ff <= REG_RESET_VAL;
      end
      else
      begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign CPU_RST = cpu_rst_ff;
   assign PLD_RST_B = pld_rst_b_ff;
   assign USB_RST_FLAG = usb_flag_ff;
   assign REG_RDATA = rdata_ff;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RST_B);

   comb_reset_a: assert property (any_req |=> CPU_RST)
      else $error("Reset request did not reach the core");
   pld_polarity_a: assert property (PLD_RST_B == !CPU_RST)
      else $error("Logic reset is not the inverse of the core reset");
   lowv_hold_a: assert property ($fell(lowv_filt) && !lowv_dis_ff
      |-> hold_ff == HW'(LOWV_HOLD_CYC) ##1 CPU_RST)
      else $error("Low-voltage hold not started");
   lowv_enable_a: assert property (lowv_filt && !lowv_dis_ff |=> CPU_RST)
      else $error("Enabled low-voltage reset ignored");
   lowv_disable_a: assert property (reg_we && REG_ADDR == REG_PWR_CTRL
      |=> lowv_dis_ff == $past(REG_WDATA[PWR_LOWV_DIS_BIT]))
      else $error("Low-voltage disable bit not written");
   usb_flag_a: assert property (usb_det |=> usb_flag_ff)
      else $error("USB bus reset flag not set");
   usb_reset_a: assert property (usb_det && usb_rst_en_ff |=> ##1 CPU_RST)
      else $error("Enabled USB bus reset did not reset");
   wd_count_a: assert property (mtick_ff && wd_en && !wd_reload && !cpu_rst_ff
      |=> wd_cnt_ff == $past(wd_cnt_ff) + 1'b1)
      else $error("Watchdog did not advance");
   wd_overflow_a: assert property (wd_ovf |=> wd_state_ff == WD_PULSE ##1 CPU_RST)
      else $error("Watchdog overflow without reset");
   wd_reload_a: assert property (wd_reload
      |=> wd_cnt_ff == {$past(REG_WDATA[WD_RELOAD_W-1:0]), {(WD_W - WD_RELOAD_W){1'b0}}})
      else $error("Watchdog reload value wrong");
   wd_key_a: assert property (key_ff == WD_KEY_OFF && !wd_reload && !cpu_rst_ff
      |=> $stable(wd_cnt_ff))
      else $error("Disabled watchdog counted");
   wd_reset_on_a: assert property (CPU_RST |=> wd_en)
      else $error("Watchdog left disabled by reset");
   wd_pulse_end_a: assert property (wd_state_ff == WD_PULSE && mtick_ff
      && wd_pcnt_ff == PW'(WD_PULSE_MC - 1) |=> wd_state_ff == WD_RUN)
      else $error("Watchdog pulse length wrong");
   mtick_period_a: assert property (mtick_ff |-> ##12 mtick_ff)
      else $error("Machine tick period wrong");

   wd_fire_c: cover property (wd_ovf);
   usb_rst_c: cover property (usb_det && usb_rst_en_ff);
   lowv_release_c: cover property ($fell(hold_ff != '0));
endmodule // rsw_top
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb import rsw_pkg::*;;
   // ---------------------------------------------------------------
   // Shortened counts so the hold and filter times fit the run
   // ---------------------------------------------------------------
   localparam int HOLD = 50;
   localparam int FILT = 4;
   localparam int PULSE = 4;
   localparam int WDW = 10;
   localparam int MC = OSC_PER_MCYCLE;
   localparam int WD_SPAN = 2 ** WDW;
   // Machine cycles left to overflow after the largest legal reload
   localparam int WD_LEFT = WD_SPAN - (int'(WD_RELOAD_MAX) << (WDW - WD_RELOAD_W));
   // Reset pin held low 1 ms at power-up
   localparam int PIN_POR_CYC = 1_000_000 / CLK_PERIOD_NS;
   localparam int CYC_MAX = 60000;

   logic MCLK;
   logic RST_B;
   logic RESET_PIN_B;
   logic LOWV_DET;
   logic USB_SE0;
   logic REG_WR;
   logic [7:0] REG_ADDR;
   logic [7:0] REG_WDATA;
   logic [7:0] REG_RDATA;
   logic CPU_RST;
   logic PLD_RST_B;
   logic USB_RST_FLAG;
   int error_cnt;
   int checked;
   int cycles;

   rsw_top #(
      .LOWV_HOLD_CYC(HOLD),
      .WD_PULSE_MC(PULSE),
      .LOWV_FILT_CYC(FILT),
      .WD_W(WDW)
   ) rsw_top_i (
      .MCLK(MCLK),
      .RST_B(RST_B),
      .RESET_PIN_B(RESET_PIN_B),
      .LOWV_DET(LOWV_DET),
      .USB_SE0(USB_SE0),
      .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR),
      .CPU_RST(CPU_RST),
      .PLD_RST_B(PLD_RST_B),
      .USB_RST_FLAG(USB_RST_FLAG),
      .REG_RDATA(REG_RDATA)
   );

   initial
   begin
      MCLK = 1'b0;
      forever #(CLK_PERIOD_NS / 2) MCLK = ~MCLK;
   end

   // ---------------------------------------------------------------
   // Checking and bus helpers
   // ---------------------------------------------------------------
   task automatic give_verdict();
      $display("errors %0d, comparisons %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic chk1(input logic seen, input logic exp, input string what);
      chk({7'h00, seen}, {7'h00, exp}, what);
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge MCLK);
   endtask

   // Strobe drops for a full cycle so back-to-back writes stay distinct
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      REG_ADDR = a;
      REG_WDATA = d;
      REG_WR = 1'b1;
      tick(1);
      REG_WR = 1'b0;
      tick(1);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      REG_ADDR = a;
      tick(1);
      chk(REG_RDATA, exp, what);
   endtask

   task automatic wait_rst(input logic v, input int maxc, input string what);
      int i;
      i = 0;
      while (CPU_RST !== v && i < maxc)
      begin
         tick(1);
         i++;
      end
      chk1(CPU_RST, v, what);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_por();
      RST_B = 1'b0;
      tick(3);
      chk1(CPU_RST, 1'b1, "cpu reset in por");
      chk1(PLD_RST_B, 1'b0, "pld reset in por");
      chk(REG_RDATA, 8'h00, "rdata in por");
      chk1(USB_RST_FLAG, 1'b0, "usb flag in por");
      RST_B = 1'b1;
      tick(PIN_POR_CYC);
      chk1(CPU_RST, 1'b1, "pin held at power-up");
      RESET_PIN_B = 1'b1;
      wait_rst(1'b0, 10, "release after por");
      chk1(PLD_RST_B, 1'b1, "pld release");
      rd(REG_WD_KEY, 8'h00, "key after por");
      rd(REG_WD_RELOAD, 8'h00, "counter after por");
   endtask

   task automatic t_pin();
      wr(REG_WD_KEY, 8'haa);
      RESET_PIN_B = 1'b0;
      wait_rst(1'b1, 4, "pin reset");
      chk1(PLD_RST_B, 1'b0, "pld on pin");
      tick(5);
      RESET_PIN_B = 1'b1;
      wait_rst(1'b0, 5, "pin release");
      rd(REG_WD_KEY, 8'h00, "key cleared");
   endtask

   task automatic t_regs();
      wr(REG_WD_RELOAD, 8'h1e);
      rd(REG_WD_RELOAD, 8'h1e, "reload 1e");
      wr(REG_WD_RELOAD, 8'h7f);
      rd(REG_WD_RELOAD, 8'h1e, "reload 7f ignored");
      wr(REG_WD_RELOAD, WD_RELOAD_MAX);
      rd(REG_WD_RELOAD, 8'h7e, "reload 7e");
      wr(REG_WD_RELOAD, 8'h00);
      rd(REG_WD_RELOAD, 8'h00, "reload zero");
      wr(REG_WD_KEY, 8'h55);
      rd(REG_WD_KEY, 8'h55, "key 55");
      wr(REG_WD_KEY, 8'h54);
      rd(REG_WD_KEY, 8'h54, "key 54");
      rd(8'h10, 8'h00, "unmapped read");
   endtask

   task automatic t_lowv();
      int n;
      LOWV_DET = 1'b1;
      tick(FILT - 2);
      LOWV_DET = 1'b0;
      tick(12);
      chk1(CPU_RST, 1'b0, "short lowv ignored");
      wr(REG_WD_KEY, 8'h55);
      LOWV_DET = 1'b1;
      wait_rst(1'b1, FILT + 8, "lowv reset");
      tick(10);
      LOWV_DET = 1'b0;
      n = 0;
      while (CPU_RST === 1'b1 && n < 200)
      begin
         tick(1);
         n++;
      end
      chk1(n >= HOLD, 1'b1, "lowv hold too short");
      chk1(n <= HOLD + 12, 1'b1, "lowv hold too long");
      rd(REG_WD_KEY, 8'h00, "key after lowv");
   endtask

   task automatic t_lowv_off();
      wr(REG_PWR_CTRL, 8'h20);
      rd(REG_PWR_CTRL, 8'h20, "power control readback");
      LOWV_DET = 1'b1;
      tick(20);
      chk1(CPU_RST, 1'b0, "lowv disabled");
      LOWV_DET = 1'b0;
      tick(10);
      wr(REG_PWR_CTRL, 8'h00);
      LOWV_DET = 1'b1;
      wait_rst(1'b1, FILT + 8, "lowv enabled again");
      LOWV_DET = 1'b0;
      wait_rst(1'b0, HOLD + 20, "lowv release");
      rd(REG_PWR_CTRL, 8'h00, "low-voltage reset enabled");
   endtask

   task automatic t_usb();
      // Under four tick samples of SE0 must not count as bus reset
      USB_SE0 = 1'b1;
      tick(30);
      USB_SE0 = 1'b0;
      tick(24);
      chk1(USB_RST_FLAG, 1'b0, "short se0");
      USB_SE0 = 1'b1;
      tick(8 * MC);
      chk1(USB_RST_FLAG, 1'b1, "se0 flag");
      chk1(CPU_RST, 1'b0, "usb reset disabled");
      rd(REG_USB_ISTA, 8'h10, "status readback");
      USB_SE0 = 1'b0;
      // Long enough for a tick to see the idle bus and rearm the run count
      tick(2 * MC);
      wr(REG_USB_ISTA, 8'h10);
      tick(1);
      chk1(USB_RST_FLAG, 1'b0, "flag cleared");
      wr(REG_USB_IEN, 8'h40);
      rd(REG_USB_IEN, 8'h40, "enable readback");
      USB_SE0 = 1'b1;
      wait_rst(1'b1, 8 * MC, "usb reset");
      chk1(USB_RST_FLAG, 1'b1, "flag with reset");
      USB_SE0 = 1'b0;
      wait_rst(1'b0, 20, "usb release");
      wr(REG_USB_ISTA, 8'h10);
      wr(REG_USB_IEN, 8'h00);
      tick(1);
      chk1(USB_RST_FLAG, 1'b0, "flag cleared end");
   endtask

   task automatic t_wd();
      int n;
      int m;
      wr(REG_WD_KEY, WD_KEY_OFF);
      wr(REG_WD_RELOAD, WD_RELOAD_MAX);
      tick(2 * WD_LEFT * MC);
      chk1(CPU_RST, 1'b0, "disabled watchdog fired");
      rd(REG_WD_RELOAD, WD_RELOAD_MAX, "disabled watchdog counted");
      wr(REG_WD_KEY, 8'h54);
      wr(REG_WD_RELOAD, WD_RELOAD_MAX);
      n = 0;
      while (CPU_RST !== 1'b1 && n < 2 * WD_LEFT * MC)
      begin
         tick(1);
         n++;
      end
      chk1(n >= (WD_LEFT - 1) * MC + 1, 1'b1, "watchdog fired early");
      chk1(n <= WD_LEFT * MC, 1'b1, "watchdog fired late");
      m = 0;
      while (CPU_RST === 1'b1 && m < 4 * PULSE * MC)
      begin
         tick(1);
         m++;
      end
      chk(8'(m), 8'(PULSE * MC), "watchdog pulse length");
      rd(REG_WD_KEY, 8'h00, "key after watchdog reset");
      rd(REG_WD_RELOAD, 8'h00, "counter after watchdog reset");
      // Each service comes just before overflow; zero must clear it all
      repeat (2)
      begin
         tick((WD_SPAN - 24) * MC);
         wr(REG_WD_RELOAD, 8'h00);
      end
      chk1(CPU_RST, 1'b0, "serviced watchdog fired");
   endtask

   // ---------------------------------------------------------------
   // Hang guard and main sequence
   // ---------------------------------------------------------------
   always @(posedge MCLK)
   begin
      cycles++;
      if (cycles == CYC_MAX)
      begin
         error_cnt++;
         $display("wrong value at %0t: run did not finish", $time);
         give_verdict();
      end
   end

   initial
   begin
      error_cnt = 0;
      checked = 0;
      cycles = 0;
      RST_B = 1'b0;
      RESET_PIN_B = 1'b0;
      LOWV_DET = 1'b0;
      USB_SE0 = 1'b0;
      REG_WR = 1'b0;
      REG_ADDR = 8'h00;
      REG_WDATA = 8'h00;
      tick(1);
      t_por();
      t_pin();
      t_regs();
      t_lowv();
      t_lowv_off();
      t_usb();
      t_wd();
      give_verdict();
   end
endmodule // tb
`default_nettype wire
